// [hdl/ocs_config_store.sv]
// top: stored configuration mirrors, program / reload / fault-recovery commands
//
// Function
// - The stored common-electrode lower bound is 8 bits at 0x21 and read-only.
// - The stored common-electrode upper bound is 8 bits at 0x22 and read-only.
// - Stored bits 5:0 at 0x23 set both analog supplies, coded like working register 0x13.
// - Stored bit 6 at 0x24 set to 1 runs the positive charge pump with two stages.
// - Stored bits 5:0 at 0x24 set the gate-high level, coded like working register 0x14.
// - Stored bits 5:0 at 0x25 set the gate-low level, coded like working register 0x15.
// - A write to 0x78 programs working registers 0x07..0x15 into stored 0x17..0x25.
// - A write to 0x79 copies the stored registers back into the working registers.
// - A write to 0x7A leaves any latched fault mode and resumes operation.
// - The recovery command clears every recorded fault indication except one raised in the same cycle.
// - Stored 8-bit value at 0x1D holds the sense voltage taken at 25 degrees.
`timescale 1ns/1ps
module ocs_config_store #(
    parameter int FAULT_W = 8
) (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                rst_n,
    // register access from the serial interface
    input  wire ocs_pkg::ocs_req_s   req,
    output logic [7:0]               rdata,
    output logic                     rvalid,
    output logic                     busy,
    // working register file port
    output logic                     work_rd,
    output logic [7:0]               work_addr,
    input  wire logic [7:0]          work_rdata,
    output logic                     work_wr,
    output logic [7:0]               work_wdata,
    // fault handling
    input  wire logic [FAULT_W-1:0]  fault_event,
    output logic [FAULT_W-1:0]       fault_record,
    output logic                     fault_latched,
    // decoded stored settings
    output ocs_pkg::ocs_cfg_s        cfg
);
    initial begin
        if (FAULT_W < 1 || FAULT_W > 32)
            $error("ocs_config_store: FAULT_W out of range");
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic cmd_program;
    logic cmd_reload;
    logic cmd_recover;

    assign cmd_program = req.wr && req.addr == ocs_pkg::PROGRAM_CMD_ADDR;
    assign cmd_reload  = req.wr && req.addr == ocs_pkg::RELOAD_CMD_ADDR;
    assign cmd_recover = req.wr && req.addr == ocs_pkg::RECOVER_CMD_ADDR;

    // ------------------------------------------------------------
    // copy sequencer
    // ------------------------------------------------------------
    ocs_pkg::ocs_state_e state;
    ocs_pkg::ocs_state_e next_state;
    logic [3:0]          idx;
    logic [3:0]          next_idx;
    logic                fetch;
    logic                next_fetch;
    logic                st_wr;
    logic [3:0]          st_idx;
    logic [7:0]          st_data;
    logic [ocs_pkg::STORE_DEPTH-1:0][7:0] store;
    logic                next_work_rd;
    logic [7:0]          next_work_addr;
    logic                next_work_wr;
    logic [7:0]          next_work_wdata;
    logic                next_busy;

    // program: read a working word, next cycle burn it; reload: write one word per cycle
    always_comb
    begin
        next_state      = state;
        next_idx        = idx;
        next_fetch      = 1'b0;
        next_work_rd    = 1'b0;
        next_work_wr    = 1'b0;
        next_work_addr  = work_addr;
        next_work_wdata = work_wdata;
        st_wr           = 1'b0;
        st_idx          = idx;
        st_data         = work_rdata;
        case (state)
            ocs_pkg::OCS_IDLE:
            begin
                next_idx = 4'h0;
                if (cmd_program)
                    next_state = ocs_pkg::OCS_PROGRAM;
                else if (cmd_reload)
                    next_state = ocs_pkg::OCS_RELOAD;
            end
            ocs_pkg::OCS_PROGRAM:
            begin
                if (!fetch)
                begin
                    next_work_rd   = 1'b1;
                    next_work_addr = ocs_pkg::WORK_FIRST_ADDR + 8'(idx);
                    next_fetch     = 1'b1;
                end
                else
                begin
                    st_wr    = 1'b1;
                    next_idx = idx + 4'h1;
                    if (idx == 4'(ocs_pkg::STORE_DEPTH - 1))
                        next_state = ocs_pkg::OCS_IDLE;
                end
            end
            ocs_pkg::OCS_RELOAD:
            begin
                next_work_wr    = 1'b1;
                next_work_addr  = ocs_pkg::WORK_FIRST_ADDR + 8'(idx);
                next_work_wdata = store[idx];
                next_idx        = idx + 4'h1;
                if (idx == 4'(ocs_pkg::STORE_DEPTH - 1))
                    next_state = ocs_pkg::OCS_IDLE;
            end
            default:
                next_state = ocs_pkg::OCS_IDLE;
        endcase
        next_busy = next_state != ocs_pkg::OCS_IDLE;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state      <= ocs_pkg::OCS_IDLE;
            idx        <= 4'h0;
            fetch      <= 1'b0;
            work_rd    <= 1'b0;
            work_wr    <= 1'b0;
            work_addr  <= 8'h00;
            work_wdata <= 8'h00;
            busy       <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            idx        <= next_idx;
            fetch      <= next_fetch;
            work_rd    <= next_work_rd;
            work_wr    <= next_work_wr;
            work_addr  <= next_work_addr;
            work_wdata <= next_work_wdata;
            busy       <= next_busy;
        end
    end

    // host writes never reach the array; only the sequencer does
    ocs_store_array #(
        .DEPTH (ocs_pkg::STORE_DEPTH)
    ) u_array (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .wr_en    (st_wr),
        .wr_idx   (st_idx),
        .wr_data  (st_data),
        .contents (store)
    );

    // ------------------------------------------------------------
    // faults and recovery
    // ------------------------------------------------------------
    logic [FAULT_W-1:0] next_fault_record;
    logic               next_fault_latched;

    // a fault in the recovery cycle survives it: a restart must never hide a new event
    always_comb
    begin
        next_fault_record  = fault_record | fault_event;
        next_fault_latched = fault_latched | (|fault_event);
        if (cmd_recover)
        begin
            next_fault_record  = fault_event;
            next_fault_latched = |fault_event;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            fault_record  <= '0;
            fault_latched <= 1'b0;
        end
        else
        begin
            fault_record  <= next_fault_record;
            fault_latched <= next_fault_latched;
        end
    end

    // ------------------------------------------------------------
    // read port and decoded settings
    // ------------------------------------------------------------
    logic [7:0]        next_rdata;
    ocs_pkg::ocs_cfg_s next_cfg;
    logic [7:0]        off;

    assign off = req.addr - ocs_pkg::STORE_FIRST_ADDR;

    always_comb
    begin
        next_rdata = 8'h00;
        if (req.rd && req.addr >= ocs_pkg::STORE_FIRST_ADDR
                   && req.addr <= ocs_pkg::STORE_LAST_ADDR)
            next_rdata = store[off[3:0]];
        next_cfg.common_lower   = store[4'(ocs_pkg::COMMON_LOW_ADDR - ocs_pkg::STORE_FIRST_ADDR)];
        next_cfg.common_upper   = store[4'(ocs_pkg::COMMON_HIGH_ADDR - ocs_pkg::STORE_FIRST_ADDR)];
        next_cfg.sense_room     = store[4'(ocs_pkg::SENSE_ROOM_ADDR - ocs_pkg::STORE_FIRST_ADDR)];
        next_cfg.analog_code    = store[4'(ocs_pkg::ANALOG_ADDR - ocs_pkg::STORE_FIRST_ADDR)]
                                  [ocs_pkg::LEVEL_MSB:0];
        next_cfg.gate_high_code = store[4'(ocs_pkg::GATE_HIGH_ADDR - ocs_pkg::STORE_FIRST_ADDR)]
                                  [ocs_pkg::LEVEL_MSB:0];
        next_cfg.pump_two_stage = store[4'(ocs_pkg::GATE_HIGH_ADDR - ocs_pkg::STORE_FIRST_ADDR)]
                                  [ocs_pkg::PUMP_STAGE_BIT];
        next_cfg.gate_low_code  = store[4'(ocs_pkg::GATE_LOW_ADDR - ocs_pkg::STORE_FIRST_ADDR)]
                                  [ocs_pkg::LEVEL_MSB:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
            cfg    <= '0;
        end
        else
        begin
            rdata  <= next_rdata;
            rvalid <= req.rd;
            cfg    <= next_cfg;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_program_issued;
        cmd_program && state == ocs_pkg::OCS_IDLE;
    endsequence

    property p_program_burns;
        @(posedge mclk) disable iff (!rst_n)
        s_program_issued |=> busy ##1 st_wr;
    endproperty
    a_program_burns: assert property (p_program_burns) else $error("program did not burn");

    property p_reload_writes;
        @(posedge mclk) disable iff (!rst_n)
        (cmd_reload && !cmd_program && state == ocs_pkg::OCS_IDLE) |=> ##1 work_wr
            && work_addr == ocs_pkg::WORK_FIRST_ADDR;
    endproperty
    a_reload_writes: assert property (p_reload_writes) else $error("reload did not write");

    property p_recover_clears;
        @(posedge mclk) disable iff (!rst_n)
        cmd_recover |=> fault_record == $past(fault_event)
            && fault_latched == $past(|fault_event);
    endproperty
    a_recover_clears: assert property (p_recover_clears) else $error("faults not cleared");

    property p_fault_latches;
        @(posedge mclk) disable iff (!rst_n)
        (|fault_event) |=> fault_latched;
    endproperty
    a_fault_latches: assert property (p_fault_latches) else $error("fault not latched");

    property p_cmd_read_zero;
        @(posedge mclk) disable iff (!rst_n)
        (req.rd && req.addr >= ocs_pkg::PROGRAM_CMD_ADDR
                && req.addr <= ocs_pkg::RECOVER_CMD_ADDR) |=> rdata == 8'h00;
    endproperty
    a_cmd_read_zero: assert property (p_cmd_read_zero) else $error("command read nonzero");

    property p_host_write_keeps;
        @(posedge mclk) disable iff (!rst_n)
        (req.wr && state == ocs_pkg::OCS_IDLE && !cmd_program) |=> $stable(store);
    endproperty
    a_host_write_keeps: assert property (p_host_write_keeps) else $error("store changed");

    property p_pump_bit;
        @(posedge mclk) disable iff (!rst_n)
        ##1 cfg.pump_two_stage
            == $past(store[4'(ocs_pkg::GATE_HIGH_ADDR - ocs_pkg::STORE_FIRST_ADDR)][6]);
    endproperty
    a_pump_bit: assert property (p_pump_bit) else $error("pump stage mismatch");

    property p_low_bound_read;
        @(posedge mclk) disable iff (!rst_n)
        (req.rd && req.addr == ocs_pkg::COMMON_LOW_ADDR) |=> rdata == $past(store[10]);
    endproperty
    a_low_bound_read: assert property (p_low_bound_read) else $error("lower bound read");

endmodule : ocs_config_store

// [hdl/ocs_pkg.sv]
// package: register map, field layout and shared types of the stored configuration block
package ocs_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] WORK_FIRST_ADDR   = 8'h07;
    localparam logic [7:0] WORK_LAST_ADDR    = 8'h15;
    localparam logic [7:0] STORE_FIRST_ADDR  = 8'h17;
    localparam logic [7:0] STORE_LAST_ADDR   = 8'h25;
    localparam logic [7:0] SENSE_ROOM_ADDR   = 8'h1D;
    localparam logic [7:0] COMMON_LOW_ADDR   = 8'h21;
    localparam logic [7:0] COMMON_HIGH_ADDR  = 8'h22;
    localparam logic [7:0] ANALOG_ADDR       = 8'h23;
    localparam logic [7:0] GATE_HIGH_ADDR    = 8'h24;
    localparam logic [7:0] GATE_LOW_ADDR     = 8'h25;
    localparam logic [7:0] PROGRAM_CMD_ADDR  = 8'h78;
    localparam logic [7:0] RELOAD_CMD_ADDR   = 8'h79;
    localparam logic [7:0] RECOVER_CMD_ADDR  = 8'h7A;

    // ------------------------------------------------------------
    // field layout and sizes
    // ------------------------------------------------------------
    localparam int         STORE_DEPTH       = 15;
    localparam int         LEVEL_MSB         = 5;
    localparam int         PUMP_STAGE_BIT    = 6;
    localparam logic [7:0] STORE_RESET       = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ocs_req_s;

    typedef struct packed {
        logic [7:0] common_lower;
        logic [7:0] common_upper;
        logic [7:0] sense_room;
        logic [5:0] analog_code;
        logic [5:0] gate_high_code;
        logic       pump_two_stage;
        logic [5:0] gate_low_code;
    } ocs_cfg_s;

    typedef enum logic [1:0] {
        OCS_IDLE    = 2'b00,
        OCS_PROGRAM = 2'b01,
        OCS_RELOAD  = 2'b10
    } ocs_state_e;

endpackage : ocs_pkg

// [hdl/ocs_store_array.sv]
// nonvolatile array model: one entry per stored register, written only by the sequencer
`timescale 1ns/1ps
module ocs_store_array #(
    parameter int DEPTH = ocs_pkg::STORE_DEPTH
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // write port
    input  wire logic             wr_en,
    input  wire logic [3:0]       wr_idx,
    input  wire logic [7:0]       wr_data,
    // contents
    output logic [DEPTH-1:0][7:0] contents
);
    initial begin
        if (DEPTH < 1 || DEPTH > 16)
            $error("ocs_store_array: DEPTH out of range");
    end

    logic [DEPTH-1:0][7:0] next_contents;

    // ------------------------------------------------------------
    // per-entry write
    // ------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_comb
        begin
            next_contents[i] = contents[i];
            if (wr_en && wr_idx == 4'(i))
                next_contents[i] = wr_data;
        end
    end

    // reset stands in for an unprogrammed part
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            contents <= '{default: ocs_pkg::STORE_RESET};
        else
            contents <= next_contents;
    end

endmodule : ocs_store_array

// [sim/ocs_work_model.sv]
// working register file model seen by the copy sequencer of the stored configuration block
`timescale 1ns/1ps
module ocs_work_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // working register port
    input  wire logic       work_rd,
    input  wire logic [7:0] work_addr,
    output logic [7:0]      work_rdata,
    input  wire logic       work_wr,
    input  wire logic [7:0] work_wdata,
    // activity counts
    output int              n_rd,
    output int              n_wr
);
    logic [7:0] mem [0:255];
    logic [7:0] last;

    // idle bus shows the inverse of the last byte, so a late sample never matches
    assign work_rdata = work_rd ? mem[work_addr] : ~last;

    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            n_rd <= 0;
            n_wr <= 0;
            last <= 8'h00;
        end
        else
        begin
            if (work_rd)
            begin
                n_rd <= n_rd + 1;
                last <= mem[work_addr];
            end
            if (work_wr)
            begin
                mem[work_addr] <= work_wdata;
                n_wr           <= n_wr + 1;
            end
        end
    end
endmodule : ocs_work_model

// [sim/ocs_config_store_bench.sv]
// self-checking bench of the stored configuration block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module ocs_config_store_bench;
    logic              mclk;
    logic              rst_n;
    ocs_pkg::ocs_req_s req;
    logic [7:0]        rdata;
    logic              rvalid;
    logic              busy;
    logic              work_rd;
    logic [7:0]        work_addr;
    logic [7:0]        work_rdata;
    logic              work_wr;
    logic [7:0]        work_wdata;
    logic [7:0]        fault_event;
    logic [7:0]        fault_record;
    logic              fault_latched;
    ocs_pkg::ocs_cfg_s cfg;
    int                n_rd;
    int                n_wr;
    int                errors;
    int                n_tests;
    int                k;
    int                c0;
    logic [7:0]        e [0:14];

    ocs_config_store dut_u (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata),
        .rvalid(rvalid), .busy(busy), .work_rd(work_rd), .work_addr(work_addr),
        .work_rdata(work_rdata), .work_wr(work_wr), .work_wdata(work_wdata),
        .fault_event(fault_event), .fault_record(fault_record),
        .fault_latched(fault_latched), .cfg(cfg));

    ocs_work_model work_u (.mclk(mclk), .rst_n(rst_n), .work_rd(work_rd),
        .work_addr(work_addr), .work_rdata(work_rdata), .work_wr(work_wr),
        .work_wdata(work_wdata), .n_rd(n_rd), .n_wr(n_wr));

    always #10 mclk = ~mclk;

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        req <= '0;
    endtask : reg_wr

    task automatic chk_rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        req <= '0;
        #1;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK(nm, exp, rdata)
    endtask : chk_rd

    task automatic wait_idle();
        int i;
        for (i = 0; i < 200 && busy !== 1'b0; i++)
            @(posedge mclk) #1;
        `CHK("busy_end", 1'b0, busy)
    endtask : wait_idle

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        req = '0;
        fault_event = '0;
        errors = 0;
        n_tests = 0;
        for (k = 0; k < 256; k++) work_u.mem[k] = 8'h00;
        for (k = 0; k < 15; k++) e[k] = 8'h40 + 8'h0B * k[7:0];
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        for (k = 0; k < 15; k++) chk_rd("blank", 8'h17 + k[7:0], ocs_pkg::STORE_RESET);
        $display("test reset done");

        for (k = 0; k < 15; k++) work_u.mem[8'h07 + k] = e[k];
        c0 = n_wr;
        reg_wr(ocs_pkg::PROGRAM_CMD_ADDR, 8'hC7);
        #1;
        `CHK("busy_prog", 1'b1, busy)
        repeat (3) @(posedge mclk);
        // reload while busy must be ignored
        reg_wr(ocs_pkg::RELOAD_CMD_ADDR, 8'h01);
        wait_idle();
        `CHK("prog_reads", 15, n_rd)
        `CHK("prog_writes", c0, n_wr)
        for (k = 0; k < 15; k++) chk_rd("store", 8'h17 + k[7:0], e[k]);
        `CHK("common_lower", e[10], cfg.common_lower)
        `CHK("common_upper", e[11], cfg.common_upper)
        `CHK("sense_room", e[6], cfg.sense_room)
        `CHK("analog_code", e[12][5:0], cfg.analog_code)
        `CHK("pump_two_stage", e[13][6], cfg.pump_two_stage)
        `CHK("gate_high_code", e[13][5:0], cfg.gate_high_code)
        `CHK("gate_low_code", e[14][5:0], cfg.gate_low_code)
        $display("test program done");

        reg_wr(ocs_pkg::COMMON_LOW_ADDR, 8'hFF);
        chk_rd("ro_lower", ocs_pkg::COMMON_LOW_ADDR, e[10]);
        reg_wr(ocs_pkg::COMMON_HIGH_ADDR, ~e[11]);
        chk_rd("ro_upper", ocs_pkg::COMMON_HIGH_ADDR, e[11]);
        reg_wr(ocs_pkg::GATE_HIGH_ADDR, ~e[13]);
        chk_rd("ro_gate_high", ocs_pkg::GATE_HIGH_ADDR, e[13]);
        for (k = 0; k < 3; k++) chk_rd("cmd_read", 8'h78 + k[7:0], 8'h00);
        chk_rd("unmapped", 8'h30, 8'h00);
        $display("test read only done");

        for (k = 0; k < 15; k++) work_u.mem[8'h07 + k] = ~e[k];
        c0 = n_wr;
        reg_wr(ocs_pkg::RELOAD_CMD_ADDR, 8'h00);
        #1;
        `CHK("busy_reload", 1'b1, busy)
        wait_idle();
        // busy drops while the last word is still on its way
        @(posedge mclk);
        #1;
        `CHK("reload_writes", c0 + 15, n_wr)
        for (k = 0; k < 15; k++) `CHK("work", e[k], work_u.mem[8'h07 + k])
        $display("test reload done");

        @(posedge mclk);
        fault_event <= 8'h5A;
        @(posedge mclk);
        fault_event <= 8'h00;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("fault_sticky", 8'h5A, fault_record)
        `CHK("fault_latch", 1'b1, fault_latched)
        reg_wr(ocs_pkg::RECOVER_CMD_ADDR, 8'h3C);
        #1;
        `CHK("record_clear", 8'h00, fault_record)
        `CHK("latch_clear", 1'b0, fault_latched)
        @(posedge mclk);
        fault_event <= 8'hA5;
        @(posedge mclk);
        fault_event <= 8'h81;
        req <= '{wr: 1'b1, rd: 1'b0, addr: ocs_pkg::RECOVER_CMD_ADDR, wdata: 8'hFF};
        @(posedge mclk);
        fault_event <= 8'h00;
        req <= '0;
        #1;
        `CHK("set_wins", 8'h81, fault_record)
        `CHK("latch_set_wins", 1'b1, fault_latched)
        $display("test recovery done");
        end_sim();
    end

    // watchdog well beyond the fewer than 200 cycles the tests need
    initial
    begin
        repeat (5000) @(posedge mclk);
        errors++;
        end_sim();
    end
endmodule : ocs_config_store_bench
